// [design/eedm_loader.sv]
`timescale 1ns/1ps
module eedm_loader
	import eedm_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	output logic             ee_rd_req_o,
	output logic [8:0]       ee_rd_addr_o,
	input  wire logic        ee_rd_ack_i,
	input  wire logic [7:0]  ee_rd_data_i,
	output logic             load_done_o,
	output logic             ee_present_o,
	output logic             usb_disconnect_o,
	output logic [47:0]      mac_addr_o,
	output logic [7:0]       fs_poll_ms_o,
	output logic [7:0]       hs_poll_ms_o,
	output logic [7:0]       cfg_flags_o,
	output logic             bus_powered_o,
	output logic             remote_wakeup_o,
	output logic [15:0]      lang_id_o,
	input  wire logic        desc_req_i,
	input  wire logic [2:0]  desc_kind_i,
	input  wire logic [8:0]  desc_idx_i,
	input  wire logic        hs_mode_i,
	output logic             desc_valid_o,
	output logic [7:0]       desc_data_o,
	output logic [7:0]       desc_len_o,
	output logic             desc_absent_o,
	output logic             desc_end_o
);

	eedm_state_t  state_reg;
	logic [8:0]   addr_reg;
	logic         present_reg;
	logic [47:0]  mac_reg;
	logic [7:0]   fs_reg;
	logic [7:0]   hs_reg;
	logic [7:0]   flags_reg;
	logic [15:0]  lang_reg;
	logic         dv_reg;
	logic [7:0]   dd_reg;
	logic [7:0]   dl_reg;
	logic         da_reg;
	logic         de_reg;
	logic         take;
	eedm_kind_t   kind;

	eedm_buf_if buf_c ();

	eedm_byte_store u_store (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.buf_p      (buf_c.store)
	);

	assign take = ee_rd_ack_i && state_reg inside {EEDM_S_MARK, EEDM_S_LOAD};
	assign kind = eedm_kind_t'(desc_kind_i);

	// ------------------------------------------------------------
	// load sequencing: one request held per byte until acked
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_reg   <= EEDM_S_START;
			addr_reg    <= EEDM_MARK_ADDR;
			present_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				EEDM_S_START:
					state_reg <= EEDM_S_MARK;
				EEDM_S_MARK:
					if (ee_rd_ack_i)
					begin
						if (ee_rd_data_i == EEDM_MARKER)
						begin
							present_reg <= 1'b1;
							addr_reg    <= EEDM_MAC_FIRST;
							state_reg   <= EEDM_S_LOAD;
						end
						else
							state_reg <= EEDM_S_DONE;
					end
				EEDM_S_LOAD:
					if (ee_rd_ack_i)
					begin
						if (addr_reg == EEDM_LAST_ADDR)
							state_reg <= EEDM_S_DONE;
						else
							addr_reg <= 9'(addr_reg + EEDM_ONE);
					end
				EEDM_S_DONE:
					state_reg <= EEDM_S_DONE;
			endcase
		end
	end

	// whole image goes into the store; descriptors are later read raw
	assign buf_c.wr_en   = take && (state_reg == EEDM_S_LOAD ||
		ee_rd_data_i == EEDM_MARKER);
	assign buf_c.wr_addr = addr_reg;
	assign buf_c.wr_data = ee_rd_data_i;

	// ------------------------------------------------------------
	// fixed fields, captured as the bytes stream past
	// ------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			mac_reg   <= EEDM_DEF_MAC;
			fs_reg    <= EEDM_DEF_FS_IVL;
			hs_reg    <= EEDM_DEF_HS_IVL;
			flags_reg <= EEDM_DEF_FLAGS;
			lang_reg  <= EEDM_DEF_LANG;
		end
		else if (state_reg == EEDM_S_LOAD && ee_rd_ack_i)
		begin
			// shifting in puts the first stored byte in the top octet
			if (addr_reg >= EEDM_MAC_FIRST && addr_reg <= EEDM_MAC_LAST)
				mac_reg <= {mac_reg[39:0], ee_rd_data_i};
			if (addr_reg == EEDM_FS_IVL)
				fs_reg <= ee_rd_data_i;
			if (addr_reg == EEDM_HS_IVL)
				hs_reg <= ee_rd_data_i;
			if (addr_reg == EEDM_CFG_FLAGS)
				flags_reg <= ee_rd_data_i;
			if (addr_reg == EEDM_LANG_LO)
				lang_reg[7:0] <= ee_rd_data_i;
			if (addr_reg == EEDM_LANG_HI)
				lang_reg[15:8] <= ee_rd_data_i;
		end
	end

	// ------------------------------------------------------------
	// descriptor lookup
	// ------------------------------------------------------------
	always_comb
	begin
		unique case (kind)
			EEDM_K_DEVICE:
				buf_c.pair_addr = hs_mode_i ? EEDM_HS_DEV
					: EEDM_FS_DEV;
			EEDM_K_CFG_BLK:
				buf_c.pair_addr = hs_mode_i ? EEDM_HS_CFG
					: EEDM_FS_CFG;
			default:
				buf_c.pair_addr = 9'(EEDM_STR_PAIR0 +
					{5'h00, desc_kind_i, 1'b0});
		endcase
	end

	// word offset doubled; index wraps inside the image
	assign buf_c.data_addr = 9'({buf_c.off, 1'b0} + desc_idx_i);

	// one-cycle answer; a zero length flags absent, though the data byte is still registered
	always_ff @(posedge core_clk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			dv_reg <= 1'b0;
			dd_reg <= 8'h00;
			dl_reg <= 8'h00;
			da_reg <= 1'b0;
			de_reg <= 1'b0;
		end
		else
		begin
			dv_reg <= desc_req_i;
			if (desc_req_i)
			begin
				dd_reg <= buf_c.data;
				dl_reg <= buf_c.len;
				da_reg <= !present_reg || state_reg != EEDM_S_DONE ||
					buf_c.len == 8'h00;
				de_reg <= desc_idx_i >= {1'b0, buf_c.len};
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign ee_rd_req_o      = state_reg inside {EEDM_S_MARK, EEDM_S_LOAD};
	assign ee_rd_addr_o     = addr_reg;
	assign load_done_o      = state_reg == EEDM_S_DONE;
	assign usb_disconnect_o = state_reg != EEDM_S_DONE;
	assign ee_present_o     = present_reg;
	assign mac_addr_o       = mac_reg;
	assign fs_poll_ms_o     = fs_reg;
	assign hs_poll_ms_o     = hs_reg;
	assign cfg_flags_o      = flags_reg;
	assign bus_powered_o    = flags_reg[EEDM_FLAG_BUSPWR];
	assign remote_wakeup_o  = flags_reg[EEDM_FLAG_RMTWKP];
	assign lang_id_o        = lang_reg;
	assign desc_valid_o     = dv_reg;
	assign desc_data_o      = dd_reg;
	assign desc_len_o       = dl_reg;
	assign desc_absent_o    = da_reg;
	assign desc_end_o       = de_reg;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_marker_miss: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		state_reg == EEDM_S_MARK && ee_rd_ack_i &&
		ee_rd_data_i != EEDM_MARKER
		|=> load_done_o && !ee_present_o && mac_addr_o == EEDM_DEF_MAC)
		else $error("missing marker did not end load with defaults");
	a_marker_load: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		state_reg == EEDM_S_MARK && ee_rd_ack_i &&
		ee_rd_data_i == EEDM_MARKER
		|=> ee_rd_req_o && ee_rd_addr_o == EEDM_MAC_FIRST && ee_present_o)
		else $error("marker did not start image copy at byte one");
	a_usb_held: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		!load_done_o |-> usb_disconnect_o)
		else $error("usb attached before load finished");
	a_mac_octet: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		state_reg == EEDM_S_LOAD && ee_rd_ack_i &&
		addr_reg == EEDM_MAC_LAST
		|=> mac_addr_o[7:0] == $past(ee_rd_data_i) &&
		mac_addr_o[15:8] == $past(mac_addr_o[7:0]))
		else $error("mac octet order wrong");
	a_poll_ivl: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		state_reg == EEDM_S_LOAD && ee_rd_ack_i && addr_reg == EEDM_HS_IVL
		|=> hs_poll_ms_o == $past(ee_rd_data_i) ##1 $stable(hs_poll_ms_o))
		else $error("high-speed interval not captured");
	a_lang_high: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		state_reg == EEDM_S_LOAD && ee_rd_ack_i && addr_reg == EEDM_LANG_HI
		|=> lang_id_o[15:8] == $past(ee_rd_data_i))
		else $error("language id high byte not captured");
	a_zero_absent: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		desc_req_i && buf_c.len == 8'h00 |=> desc_valid_o && desc_absent_o)
		else $error("zero length string not reported absent");
	a_hs_select: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		desc_req_i && kind == EEDM_K_CFG_BLK && !hs_mode_i
		|-> buf_c.pair_addr == EEDM_FS_CFG)
		else $error("full-speed configuration pair not chosen");
	a_data_raw: assert property (
		@(posedge core_clk_i) disable iff (sys_rst_i)
		desc_req_i |-> buf_c.data_addr ==
		9'({buf_c.off, 1'b0} + desc_idx_i) ##1 desc_data_o == $past(buf_c.data))
		else $error("descriptor byte not served from doubled offset");

endmodule

// [design/eedm_pkg.sv]
package eedm_pkg;

	// ------------------------------------------------------------
	// image geometry
	// ------------------------------------------------------------
	localparam int          EEDM_ADDR_W    = 9;
	localparam int          EEDM_DEPTH     = 512;
	localparam logic [8:0]  EEDM_LAST_ADDR = 9'h1ff;
	localparam logic [7:0]  EEDM_MARKER    = 8'ha5;

	// ------------------------------------------------------------
	// fixed image layout
	// ------------------------------------------------------------
	localparam logic [8:0]  EEDM_MARK_ADDR  = 9'h000;
	localparam logic [8:0]  EEDM_MAC_FIRST  = 9'h001;
	localparam logic [8:0]  EEDM_MAC_LAST   = 9'h006;
	localparam logic [8:0]  EEDM_FS_IVL     = 9'h007;
	localparam logic [8:0]  EEDM_HS_IVL     = 9'h008;
	localparam logic [8:0]  EEDM_CFG_FLAGS  = 9'h009;
	localparam logic [8:0]  EEDM_LANG_LO    = 9'h00a;
	localparam logic [8:0]  EEDM_LANG_HI    = 9'h00b;
	localparam logic [8:0]  EEDM_STR_PAIR0  = 9'h00c;
	localparam logic [8:0]  EEDM_HS_DEV     = 9'h016;
	localparam logic [8:0]  EEDM_HS_CFG     = 9'h018;
	localparam logic [8:0]  EEDM_FS_DEV     = 9'h01a;
	localparam logic [8:0]  EEDM_FS_CFG     = 9'h01c;
	localparam logic [8:0]  EEDM_ONE        = 9'h001;

	// ------------------------------------------------------------
	// configuration flag bits and defaults
	// ------------------------------------------------------------
	localparam int          EEDM_FLAG_BUSPWR = 2;
	localparam int          EEDM_FLAG_RMTWKP = 3;
	localparam logic [47:0] EEDM_DEF_MAC     = 48'h0;
	localparam logic [7:0]  EEDM_DEF_FS_IVL  = 8'h01;
	localparam logic [7:0]  EEDM_DEF_HS_IVL  = 8'h04;
	localparam logic [7:0]  EEDM_DEF_FLAGS   = 8'h00;
	localparam logic [15:0] EEDM_DEF_LANG    = 16'h0409;

	typedef enum logic [2:0] {
		EEDM_K_MANUF,
		EEDM_K_PRODUCT,
		EEDM_K_SERIAL,
		EEDM_K_CFG_STR,
		EEDM_K_IFC_STR,
		EEDM_K_DEVICE,
		EEDM_K_CFG_BLK
	} eedm_kind_t;

	typedef enum logic [1:0] {
		EEDM_S_START,
		EEDM_S_MARK,
		EEDM_S_LOAD,
		EEDM_S_DONE
	} eedm_state_t;

endpackage

// [design/eedm_buf_if.sv]
`timescale 1ns/1ps
interface eedm_buf_if;
	import eedm_pkg::*;
	logic             wr_en;
	logic [8:0]       wr_addr;
	logic [7:0]       wr_data;
	logic [8:0]       pair_addr;
	logic [7:0]       len;
	logic [7:0]       off;
	logic [8:0]       data_addr;
	logic [7:0]       data;

	modport loader (
		output wr_en, wr_addr, wr_data, pair_addr, data_addr,
		input  len, off, data
	);
	modport store (
		input  wr_en, wr_addr, wr_data, pair_addr, data_addr,
		output len, off, data
	);
endinterface

// [design/eedm_byte_store.sv]
`timescale 1ns/1ps
module eedm_byte_store
	import eedm_pkg::*;
(
	input  wire logic   core_clk_i,
	input  wire logic   sys_rst_i,
	eedm_buf_if.store   buf_p
);

	logic [7:0] mem_reg [EEDM_DEPTH];
	logic [8:0] off_addr;

	// ------------------------------------------------------------
	// image storage, cleared so an unprogrammed part reads as empty
	// ------------------------------------------------------------
	for (genvar g = 0; g < EEDM_DEPTH; g++)
	begin : g_entry
		always_ff @(posedge core_clk_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
				mem_reg[g] <= 8'h00;
			else if (buf_p.wr_en && buf_p.wr_addr == 9'(g))
				mem_reg[g] <= buf_p.wr_data;
		end
	end

	assign off_addr   = 9'(buf_p.pair_addr + EEDM_ONE);
	assign buf_p.len  = mem_reg[buf_p.pair_addr];
	assign buf_p.off  = mem_reg[off_addr];
	assign buf_p.data = mem_reg[buf_p.data_addr];

endmodule

// [verif/eedm_ee_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// serial eeprom behind the read controller
// ------------------------------------------------------------
module eedm_ee_model
(
	input  wire logic        core_clk_i,
	input  wire logic        rd_req_i,
	input  wire logic [8:0]  rd_addr_i,
	output logic             rd_ack_o,
	output logic [7:0]       rd_data_o
);
	logic [7:0]  mem [0:511];
	int          wait_cyc = 0;
	int          cnt      = 0;
	int          rd_count = 0;

	initial
	begin
		rd_ack_o  = 1'b0;
		rd_data_o = 8'h00;
	end

	// between acks the data line flips, so sampling off the ack edge
	// picks up a wrong byte instead of a stale right one
	always @(negedge core_clk_i)
	begin
		if (rd_req_i && cnt >= wait_cyc)
		begin
			rd_ack_o  <= 1'b1;
			rd_data_o <= mem[rd_addr_i];
			cnt       <= 0;
			rd_count  <= rd_count + 1;
		end
		else
		begin
			rd_ack_o  <= 1'b0;
			rd_data_o <= ~rd_data_o;
			cnt       <= rd_req_i ? cnt + 1 : 0;
		end
	end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import eedm_pkg::*;
	logic        core_clk_i, sys_rst_i, ee_rd_req_o, ee_rd_ack_i;
	logic        load_done_o, ee_present_o, usb_disconnect_o;
	logic        bus_powered_o, remote_wakeup_o, desc_req_i, hs_mode_i;
	logic        desc_valid_o, desc_absent_o, desc_end_o;
	logic [8:0]  ee_rd_addr_o, desc_idx_i;
	logic [7:0]  ee_rd_data_i, fs_poll_ms_o, hs_poll_ms_o, cfg_flags_o;
	logic [7:0]  desc_data_o, desc_len_o;
	logic [2:0]  desc_kind_i;
	logic [15:0] lang_id_o;
	logic [47:0] mac_addr_o;
	logic [7:0]  img [0:511];
	int          num_errors = 0;
	int          cmp_count  = 0;

	eedm_loader u_eedm_loader (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.ee_rd_req_o(ee_rd_req_o), .ee_rd_addr_o(ee_rd_addr_o),
		.ee_rd_ack_i(ee_rd_ack_i), .ee_rd_data_i(ee_rd_data_i),
		.load_done_o(load_done_o), .ee_present_o(ee_present_o),
		.usb_disconnect_o(usb_disconnect_o), .mac_addr_o(mac_addr_o),
		.fs_poll_ms_o(fs_poll_ms_o), .hs_poll_ms_o(hs_poll_ms_o),
		.cfg_flags_o(cfg_flags_o), .bus_powered_o(bus_powered_o),
		.remote_wakeup_o(remote_wakeup_o), .lang_id_o(lang_id_o),
		.desc_req_i(desc_req_i), .desc_kind_i(desc_kind_i),
		.desc_idx_i(desc_idx_i), .hs_mode_i(hs_mode_i),
		.desc_valid_o(desc_valid_o), .desc_data_o(desc_data_o),
		.desc_len_o(desc_len_o), .desc_absent_o(desc_absent_o),
		.desc_end_o(desc_end_o));

	eedm_ee_model ee_model (.core_clk_i(core_clk_i), .rd_req_i(ee_rd_req_o),
		.rd_addr_i(ee_rd_addr_o), .rd_ack_o(ee_rd_ack_i),
		.rd_data_o(ee_rd_data_i));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial
	begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	task automatic chk(input string what, input logic [47:0] seen,
		input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic do_reset;
		sys_rst_i = 1'b1;
		repeat (2) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
	endtask

	task automatic wait_done;
		int n;
		n = 0;
		while (load_done_o !== 1'b1 && n < 5000)
		begin
			@(negedge core_clk_i);
			n++;
		end
		chk("load_done", load_done_o, 1'b1);
	endtask

	// leaves the request high so calls can run back to back
	task automatic desc_q(input logic [2:0] kind, input logic hs,
		input logic [8:0] idx, input logic [8:0] pair);
		logic [7:0] ln;
		logic [8:0] a;
		ln = img[pair];
		a  = {img[pair + 9'h001], 1'b0} + idx;
		desc_req_i  = 1'b1;
		desc_kind_i = kind;
		hs_mode_i   = hs;
		desc_idx_i  = idx;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("desc_valid", desc_valid_o, 1'b1);
		chk("desc_absent", desc_absent_o, ln == 8'h00);
		if (ln != 8'h00)
		begin
			chk("desc_len", desc_len_o, ln);
			chk("desc_data", desc_data_o, img[a]);
			chk("desc_end", desc_end_o, idx >= ln);
		end
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_load;
		ee_model.wait_cyc = 2;
		do_reset();
		desc_req_i  = 1'b1;
		desc_kind_i = 3'h5;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		chk("early absent", desc_absent_o, 1'b1);
		desc_req_i = 1'b0;
		repeat (300) @(negedge core_clk_i);
		chk("disc mid", usb_disconnect_o, 1'b1);
		chk("done mid", load_done_o, 1'b0);
		wait_done();
		chk("disc end", usb_disconnect_o, 1'b0);
		chk("present", ee_present_o, 1'b1);
		chk("reads", ee_model.rd_count, 512);
		$display("test_load done");
	endtask

	task automatic test_fields;
		chk("mac", mac_addr_o, 48'h123456789abc);
		chk("fs_poll", fs_poll_ms_o, img[7]);
		chk("hs_poll", hs_poll_ms_o, img[8]);
		chk("flags", cfg_flags_o, img[9]);
		chk("buspwr", bus_powered_o, 1'b1);
		chk("wakeup", remote_wakeup_o, 1'b0);
		chk("lang", lang_id_o, {img[11], img[10]});
		$display("test_fields done");
	endtask

	task automatic test_descs;
		logic [2:0] kinds [9] = '{0, 1, 2, 3, 4, 5, 5, 6, 6};
		logic       hss   [9] = '{0, 0, 0, 0, 1, 1, 0, 1, 0};
		logic [8:0] pairs [9] = '{9'h00c, 9'h00e, 9'h010, 9'h012, 9'h014,
			9'h016, 9'h01a, 9'h018, 9'h01c};
		logic [8:0] ln;
		for (int i = 0; i < 9; i++)
		begin
			ln = {1'b0, img[pairs[i]]};
			desc_q(kinds[i], hss[i], 9'h000, pairs[i]);
			desc_q(kinds[i], hss[i], ln - 9'h001, pairs[i]);
			desc_q(kinds[i], hss[i], ln, pairs[i]);
		end
		desc_req_i = 1'b0;
		$display("test_descs done");
	endtask

	task automatic test_blank;
		ee_model.mem[0] = 8'h5a;
		ee_model.wait_cyc = 0;
		ee_model.rd_count = 0;
		do_reset();
		wait_done();
		chk("blank reads", ee_model.rd_count, 1);
		chk("blank present", ee_present_o, 1'b0);
		chk("blank mac", mac_addr_o, EEDM_DEF_MAC);
		chk("blank lang", lang_id_o, EEDM_DEF_LANG);
		chk("blank disc", usb_disconnect_o, 1'b0);
		desc_q(3'h1, 1'b0, 9'h000, 9'h012);
		desc_req_i = 1'b0;
		$display("test_blank done");
	endtask

	initial
	begin
		sys_rst_i   = 1'b1;
		desc_req_i  = 1'b0;
		desc_kind_i = 3'h0;
		desc_idx_i  = 9'h000;
		hs_mode_i   = 1'b0;
		for (int i = 0; i < 512; i++)
			img[i] = 8'(i * 7 + 3);
		img[0:29] = '{8'ha5, 8'h12, 8'h34, 8'h56, 8'h78, 8'h9a, 8'hbc,
			8'h01, 8'h04, 8'h04, 8'h09, 8'h04, 8'h0a, 8'h0f, 8'h10,
			8'h14, 8'h10, 8'h1c, 8'h00, 8'h33, 8'h06, 8'h50, 8'h12,
			8'h24, 8'h12, 8'h2d, 8'h12, 8'h36, 8'h12, 8'h3f};
		for (int i = 0; i < 512; i++)
			ee_model.mem[i] = img[i];
		@(negedge core_clk_i);
		test_load();
		test_fields();
		test_descs();
		test_blank();
		end_sim();
	end

	// whole run is under two thousand cycles; this leaves a wide margin
	initial
	begin
		#200us;
		num_errors++;
		end_sim();
	end
endmodule
